// [common/osc_ctrl_pkg.sv]
// Constants and types for the oscillator stop and clock select block
package osc_ctrl_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_RUN    = 8'h04;
   localparam logic [7:0] OFS_CPUCLK = 8'h08;
   localparam logic [7:0] OFS_OPT    = 8'h0C;

   // ==========================================================
   // Oscillator mode register fields
   localparam int         MODE_EXT_CLK  = 7;
   localparam int         MODE_MAIN_OSC = 6;
   localparam int         MODE_SUB_PIN  = 4;
   localparam int         MODE_AMP_GAIN = 0;
   localparam logic [7:0] MODE_MASK     = 8'hD1;
   localparam logic [7:0] MODE_RESET    = 8'h00;

   // Run control register fields
   localparam int         RUN_SUB_STOP  = 6;
   localparam int         RUN_FAST_STOP = 0;
   localparam logic [7:0] RUN_RESET     = 8'h40;

   // CPU clock select register fields
   localparam int         CK_SUB_STAT   = 7;
   localparam int         CK_SUB_SEL    = 6;
   localparam int         CK_MAIN_STAT  = 5;
   localparam int         CK_MAIN_SEL   = 4;
   localparam logic [7:0] CK_RESET      = 8'h00;

   // Option byte fields
   localparam int         OPT_WDT_STBY  = 0;
   localparam int         OPT_WDT_EN    = 4;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_BYTE    = 3'h0;

   // ==========================================================
   // Timing
   localparam int         CLK_PERIOD_NS  = 25;
   localparam int         CLK_KHZ        = 40000;
   localparam int         SWITCH_TIME_NS = 100;
   localparam int         SWITCH_CYC     = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SLOW_OSC_KHZ   = 240;
   localparam int         SLOW_TICK_CYC  = CLK_KHZ / SLOW_OSC_KHZ;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {SRC_FAST, SRC_MAIN, SRC_SUB} clk_src_e;
   typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_STOP} pwr_mode_e;

   typedef struct packed {
      logic fast_on;
      logic main_on;
      logic sub_on;
      logic slow_on;
   } osc_en_s;

   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic [2:0] size;
      logic       valid;
   } ahb_req_s;

endpackage : osc_ctrl_pkg

// [hdl/osc_stop_and_clock_select.sv]
// Oscillator start/stop control and CPU clock source selection
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps

module osc_stop_and_clock_select (
   input  wire  logic                        hclk,
   input  wire  logic                        hresetn,
   input  wire  logic                        clk_en,
   // AHB-Lite slave
   input  wire  logic                        hsel,
   input  wire  logic [31:0]                 haddr,
   input  wire  logic [1:0]                  htrans,
   input  wire  logic                        hwrite,
   input  wire  logic [2:0]                  hsize,
   input  wire  logic [31:0]                 hwdata,
   input  wire  logic                        hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic [31:0]                       hrdata,
   // Core events and straps
   input  wire  logic                        stop_exec,
   input  wire  logic                        halt_exec,
   input  wire  logic                        standby_release,
   input  wire  logic [7:0]                  option_byte,
   input  wire  logic                        lvd_default_on,
   input  wire  logic                        supply_ok,
   input  wire  logic                        main_osc_ready,
   // Clock control outputs
   output osc_ctrl_pkg::osc_en_s             osc_en,
   output osc_ctrl_pkg::clk_src_e            cpu_clk_src,
   output logic                              cpu_clk_div2,
   output logic                              periph_on_sub,
   output logic                              analog_serial_ok,
   output logic                              sub_pins_crystal,
   output logic                              wdt_tick,
   output logic                              cpu_reset_hold
);

   // ==========================================================
   // Registers
   logic [7:0]               mode_ff;
   logic                     mode_written_ff;
   logic [7:0]               run_ff;
   logic                     sub_sel_ff;
   logic                     main_sel_ff;
   logic [7:0]               opt_ff;
   logic                     opt_loaded_ff;
   osc_ctrl_pkg::ahb_req_s   req_ff;
   osc_ctrl_pkg::pwr_mode_e  pm_ff;
   osc_ctrl_pkg::clk_src_e   src_ff;
   logic [3:0]               sw_cnt_ff;
   logic [7:0]               tick_cnt_ff;
   logic                     tick_ff;
   logic                     hold_ff;
   logic [31:0]              rdata_ff;
   osc_ctrl_pkg::osc_en_s    en_ff;

   osc_ctrl_pkg::clk_src_e   target;
   logic                     target_ready;
   logic                     addr_take;
   logic                     wr_mode;
   logic                     wr_run;
   logic                     wr_ck;
   logic [7:0]               ck_rd;
   logic                     nxt_slow_on;

   // ==========================================================
   // AHB-Lite address phase
   assign addr_take = hsel & hready & (htrans == osc_ctrl_pkg::HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_ff <= '0;
      end else if (clk_en) begin
         if (hready) begin
            req_ff.valid <= addr_take;
            req_ff.addr  <= haddr[7:0];
            req_ff.write <= hwrite;
            req_ff.size  <= hsize;
         end
      end
   end

   assign wr_mode = req_ff.valid & req_ff.write & (req_ff.addr == osc_ctrl_pkg::OFS_MODE);
   assign wr_run  = req_ff.valid & req_ff.write & (req_ff.addr == osc_ctrl_pkg::OFS_RUN);
   assign wr_ck   = req_ff.valid & req_ff.write & (req_ff.addr == osc_ctrl_pkg::OFS_CPUCLK);

   // Status read back from the completed source only
   always_comb begin
      ck_rd = 8'h00;
      ck_rd[osc_ctrl_pkg::CK_SUB_STAT]  = (src_ff == osc_ctrl_pkg::SRC_SUB);
      ck_rd[osc_ctrl_pkg::CK_MAIN_STAT] = (src_ff == osc_ctrl_pkg::SRC_MAIN);
      ck_rd[osc_ctrl_pkg::CK_SUB_SEL]   = sub_sel_ff;
      ck_rd[osc_ctrl_pkg::CK_MAIN_SEL]  = main_sel_ff;
   end

   // Read data registered at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (clk_en && hready) begin
         rdata_ff <= 32'h0000_0000;
         if (addr_take && !hwrite) begin
            case (haddr[7:0])
               osc_ctrl_pkg::OFS_MODE:   rdata_ff[7:0] <= mode_ff;
               osc_ctrl_pkg::OFS_RUN:    rdata_ff[7:0] <= run_ff;
               osc_ctrl_pkg::OFS_CPUCLK: rdata_ff[7:0] <= ck_rd;
               osc_ctrl_pkg::OFS_OPT:    rdata_ff[7:0] <= opt_ff;
               default:                  rdata_ff      <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Oscillator mode register, one byte write after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff         <= osc_ctrl_pkg::MODE_RESET;
         mode_written_ff <= 1'b0;
      end else if (clk_en) begin
         if (wr_mode && !mode_written_ff && req_ff.size == osc_ctrl_pkg::HSIZE_BYTE) begin
            mode_ff         <= hwdata[7:0] & osc_ctrl_pkg::MODE_MASK;
            mode_written_ff <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Run control and CPU clock select registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_ff <= osc_ctrl_pkg::RUN_RESET;
      end else if (clk_en && wr_run) begin
         run_ff <= 8'h00;
         run_ff[osc_ctrl_pkg::RUN_SUB_STOP]  <= hwdata[osc_ctrl_pkg::RUN_SUB_STOP];
         run_ff[osc_ctrl_pkg::RUN_FAST_STOP] <= hwdata[osc_ctrl_pkg::RUN_FAST_STOP];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sub_sel_ff  <= 1'b0;
         main_sel_ff <= 1'b0;
      end else if (clk_en && wr_ck) begin
         sub_sel_ff  <= hwdata[osc_ctrl_pkg::CK_SUB_SEL];
         main_sel_ff <= hwdata[osc_ctrl_pkg::CK_MAIN_SEL];
      end
   end

   // Option byte captured on the first edge after release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_ff        <= 8'h00;
         opt_loaded_ff <= 1'b0;
      end else if (clk_en && !opt_loaded_ff) begin
         opt_ff        <= option_byte;
         opt_loaded_ff <= 1'b1;
      end
   end

   // ==========================================================
   // Power mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_ff <= osc_ctrl_pkg::PM_RUN;
      end else if (clk_en) begin
         case (pm_ff)
            osc_ctrl_pkg::PM_RUN: begin
               if (stop_exec) begin
                  pm_ff <= osc_ctrl_pkg::PM_STOP;
               end else if (halt_exec) begin
                  pm_ff <= osc_ctrl_pkg::PM_HALT;
               end
            end
            osc_ctrl_pkg::PM_HALT,
            osc_ctrl_pkg::PM_STOP: begin
               if (standby_release) begin
                  pm_ff <= osc_ctrl_pkg::PM_RUN;
               end
            end
            default: pm_ff <= osc_ctrl_pkg::PM_RUN;
         endcase
      end
   end

   // ==========================================================
   // Oscillator enables
   // Slow oscillator waits for the option byte before it runs
   assign nxt_slow_on = opt_loaded_ff & opt_ff[osc_ctrl_pkg::OPT_WDT_EN]
                        & (opt_ff[osc_ctrl_pkg::OPT_WDT_STBY] | (pm_ff == osc_ctrl_pkg::PM_RUN));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_ff <= '0;
      end else if (clk_en) begin
         en_ff.fast_on <= ~run_ff[osc_ctrl_pkg::RUN_FAST_STOP] & (pm_ff != osc_ctrl_pkg::PM_STOP);
         en_ff.main_on <= mode_ff[osc_ctrl_pkg::MODE_MAIN_OSC] & (pm_ff != osc_ctrl_pkg::PM_STOP);
         en_ff.sub_on  <= ~run_ff[osc_ctrl_pkg::RUN_SUB_STOP] & mode_ff[osc_ctrl_pkg::MODE_SUB_PIN];
         en_ff.slow_on <= nxt_slow_on;
      end
   end

   assign osc_en           = en_ff;
   assign sub_pins_crystal = mode_ff[osc_ctrl_pkg::MODE_SUB_PIN];

   // ==========================================================
   // CPU clock source switch; slow oscillator is never a target
   always_comb begin
      if (sub_sel_ff) begin
         target = osc_ctrl_pkg::SRC_SUB;
      end else if (main_sel_ff) begin
         target = osc_ctrl_pkg::SRC_MAIN;
      end else begin
         target = osc_ctrl_pkg::SRC_FAST;
      end
   end

   always_comb begin
      case (target)
         osc_ctrl_pkg::SRC_SUB:  target_ready = en_ff.sub_on;
         osc_ctrl_pkg::SRC_MAIN: target_ready = en_ff.main_on & main_osc_ready;
         default:                target_ready = en_ff.fast_on;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_ff    <= osc_ctrl_pkg::SRC_FAST;
         sw_cnt_ff <= 4'h0;
      end else if (clk_en) begin
         if (target == src_ff || !target_ready) begin
            sw_cnt_ff <= 4'h0;
         end else if (sw_cnt_ff == 4'(osc_ctrl_pkg::SWITCH_CYC - 1)) begin
            src_ff    <= target;
            sw_cnt_ff <= 4'h0;
         end else begin
            sw_cnt_ff <= sw_cnt_ff + 4'h1;
         end
      end
   end

   assign cpu_clk_src      = src_ff;
   assign cpu_clk_div2     = (src_ff == osc_ctrl_pkg::SRC_SUB);
   assign periph_on_sub    = (src_ff == osc_ctrl_pkg::SRC_SUB);
   assign analog_serial_ok = (src_ff != osc_ctrl_pkg::SRC_SUB);

   // ==========================================================
   // Nominal watchdog tick from the slow oscillator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_ff <= 8'h00;
         tick_ff     <= 1'b0;
      end else if (clk_en) begin
         tick_ff <= 1'b0;
         if (!en_ff.slow_on) begin
            tick_cnt_ff <= 8'h00;
         end else if (tick_cnt_ff == 8'(osc_ctrl_pkg::SLOW_TICK_CYC - 1)) begin
            tick_cnt_ff <= 8'h00;
            tick_ff     <= 1'b1;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
         end
      end
   end

   assign wdt_tick = tick_ff;

   // ==========================================================
   // Reset hold while supply is below the detector level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_ff <= 1'b1;
      end else if (clk_en) begin
         hold_ff <= lvd_default_on & ~supply_ok;
      end
   end

   assign cpu_reset_hold = hold_ff;

   // ==========================================================
   // Checks
   stop_halts_fast_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && pm_ff == osc_ctrl_pkg::PM_STOP) ##1 clk_en |-> !en_ff.fast_on)
      else $error("fast oscillator runs in stop");

   fast_stop_bit_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && run_ff[osc_ctrl_pkg::RUN_FAST_STOP]) ##1 clk_en |-> !en_ff.fast_on)
      else $error("fast oscillator not halted by stop bit");

   status_code_a : assert property (@(posedge hclk) disable iff (!hresetn)
      sub_sel_ff && en_ff.sub_on && clk_en && src_ff != osc_ctrl_pkg::SRC_SUB
      |-> ##[1:8] ck_rd[osc_ctrl_pkg::CK_SUB_STAT] || !clk_en || !sub_sel_ff || !en_ff.sub_on)
      else $error("subsystem status not reported");

   mode_write_once_a : assert property (@(posedge hclk) disable iff (!hresetn)
      mode_written_ff |=> $stable(mode_ff))
      else $error("mode register changed after first write");

   sub_div_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(cpu_clk_div2) |-> $past(sub_sel_ff) && $past(en_ff.sub_on))
      else $error("halved subsystem clock without selection");

   sub_survives_stop_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && en_ff.sub_on && !run_ff[osc_ctrl_pkg::RUN_SUB_STOP] && stop_exec) ##1 clk_en |-> en_ff.sub_on)
      else $error("stop instruction halted subsystem oscillator");

   sub_stop_bit_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && run_ff[osc_ctrl_pkg::RUN_SUB_STOP]) ##1 clk_en |-> !en_ff.sub_on)
      else $error("subsystem oscillator not halted by stop bit");

   slow_standby_a : assert property (@(posedge hclk) disable iff (!hresetn)
      (clk_en && pm_ff != osc_ctrl_pkg::PM_RUN && !opt_ff[osc_ctrl_pkg::OPT_WDT_STBY]) ##1 clk_en
      |-> !en_ff.slow_on)
      else $error("slow oscillator runs in standby");

   slow_disabled_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !opt_ff[osc_ctrl_pkg::OPT_WDT_EN] |-> !en_ff.slow_on)
      else $error("slow oscillator runs with watchdog off");

   switch_delay_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(src_ff) |-> $past(sw_cnt_ff) == 4'(osc_ctrl_pkg::SWITCH_CYC - 1))
      else $error("source changed before switch time");

   cover_to_sub_c  : cover property (@(posedge hclk) disable iff (!hresetn) src_ff == osc_ctrl_pkg::SRC_SUB);
   cover_stop_c    : cover property (@(posedge hclk) disable iff (!hresetn)
      pm_ff == osc_ctrl_pkg::PM_STOP ##[1:20] pm_ff == osc_ctrl_pkg::PM_RUN);
   cover_wdt_tick_c : cover property (@(posedge hclk) disable iff (!hresetn) tick_ff);
   cover_main_c    : cover property (@(posedge hclk) disable iff (!hresetn) src_ff == osc_ctrl_pkg::SRC_MAIN);
   cover_halt_c    : cover property (@(posedge hclk) disable iff (!hresetn) pm_ff == osc_ctrl_pkg::PM_HALT);

   reset_fast_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(opt_loaded_ff) |-> src_ff == osc_ctrl_pkg::SRC_FAST && en_ff.fast_on)
      else $error("fast oscillator not running after reset");

   slow_start_a : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(opt_loaded_ff) && opt_ff[osc_ctrl_pkg::OPT_WDT_EN] && clk_en && pm_ff == osc_ctrl_pkg::PM_RUN
      |=> en_ff.slow_on)
      else $error("slow oscillator did not start after reset");

   pins_input_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !mode_written_ff |-> !sub_pins_crystal)
      else $error("subsystem pins left input mode without write");

   freeze_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
      !clk_en |=> $stable(src_ff) && $stable(en_ff) && $stable(hold_ff) && $stable(mode_ff))
      else $error("state moved while clock enable low");

endmodule : osc_stop_and_clock_select

// [tb/osc_stop_and_clock_select_bench.sv]
// Self-checking bench for the oscillator stop and clock select block
`timescale 1ns/10ps

module osc_stop_and_clock_select_bench;
   // ==========================================================
   // Signals
   logic                   hclk;
   logic                   hresetn;
   logic                   clk_en;
   logic                   hsel;
   logic [31:0]            haddr;
   logic [1:0]             htrans;
   logic                   hwrite;
   logic [2:0]             hsize;
   logic [31:0]            hwdata;
   logic                   hreadyout;
   logic                   hresp;
   logic [31:0]            hrdata;
   logic                   stop_exec;
   logic                   halt_exec;
   logic                   standby_release;
   logic [7:0]             option_byte;
   logic                   lvd_default_on;
   logic                   supply_ok;
   logic                   main_osc_ready;
   osc_ctrl_pkg::osc_en_s  osc_en;
   osc_ctrl_pkg::clk_src_e cpu_clk_src;
   logic                   cpu_clk_div2;
   logic                   periph_on_sub;
   logic                   analog_serial_ok;
   logic                   sub_pins_crystal;
   logic                   wdt_tick;
   logic                   cpu_reset_hold;
   logic                   rdy_q;
   logic [31:0]            hrd_q;
   logic [7:0]             opt;
   logic [7:0]             mval;
   int                     ticks = 0;
   int                     t0;
   int                     cycles = 0;
   int                     err_count = 0;
   int                     checks = 0;

   osc_stop_and_clock_select dut (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .stop_exec(stop_exec), .halt_exec(halt_exec),
      .standby_release(standby_release), .option_byte(option_byte), .lvd_default_on(lvd_default_on),
      .supply_ok(supply_ok), .main_osc_ready(main_osc_ready), .osc_en(osc_en), .cpu_clk_src(cpu_clk_src),
      .cpu_clk_div2(cpu_clk_div2), .periph_on_sub(periph_on_sub), .analog_serial_ok(analog_serial_ok),
      .sub_pins_crystal(sub_pins_crystal), .wdt_tick(wdt_tick), .cpu_reset_hold(cpu_reset_hold)
   );

   // ==========================================================
   // Clock, sampling and timeout
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // Outputs are stable at the falling edge, so this holds what the next rising edge sees
   always @(negedge hclk) begin
      rdy_q <= hreadyout;
      hrd_q <= hrdata;
      if (wdt_tick === 1'b1) begin
         ticks <= ticks + 1;
      end
   end

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_count++;
         stop_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask : settle

   // Single AHB transfer; address phase held until hready, then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [2:0] sz,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= osc_ctrl_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= sz;
      do @(posedge hclk); while (rdy_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (rdy_q !== 1'b1);
      q = hrd_q;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, osc_ctrl_pkg::HSIZE_BYTE, q);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 3'h2, q);
      checks++;
      if (q !== {24'h000000, exp}) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, q, exp);
      end
   endtask : rchk

   task automatic pulse(input logic [2:0] v);
      @(posedge hclk);
      {stop_exec, halt_exec, standby_release} <= v;
      @(posedge hclk);
      {stop_exec, halt_exec, standby_release} <= 3'h0;
      settle(3);
   endtask : pulse

   task automatic do_reset(input logic [7:0] o);
      @(posedge hclk);
      hresetn <= 1'b0;
      option_byte <= o;
      repeat (16) @(posedge hclk);
      @(negedge hclk);
      chk_bit(osc_en.fast_on, 1'b0);
      chk_bit(sub_pins_crystal, 1'b0);
      chk_bit(cpu_reset_hold, 1'b1);
      @(posedge hclk);
      hresetn <= 1'b1;
      settle(3);
   endtask : do_reset

   // Expected CPU clock register: both status and select at bit 7 and 6
   function automatic logic [7:0] cpu_reg(input logic sub);
      return {sub, sub, 6'h00};
   endfunction : cpu_reg

   // ==========================================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h00000000;
      {stop_exec, halt_exec, standby_release} = 3'h0;
      option_byte = 8'h10;
      lvd_default_on = 1'b0;
      supply_ok = 1'b1;
      main_osc_ready = 1'b1;
      void'($urandom(41981));
      // Watchdog on, stopped in standby
      opt = (8'($urandom()) & 8'hEE) | 8'h10;
      do_reset(opt);
      chk_bit(osc_en.fast_on, 1'b1);
      chk_bit(osc_en.slow_on, 1'b1);
      chk_bit(osc_en.sub_on, 1'b0);
      chk_bit(cpu_clk_src === osc_ctrl_pkg::SRC_FAST, 1'b1);
      rchk(osc_ctrl_pkg::OFS_MODE, osc_ctrl_pkg::MODE_RESET);
      rchk(osc_ctrl_pkg::OFS_RUN, osc_ctrl_pkg::RUN_RESET);
      rchk(osc_ctrl_pkg::OFS_CPUCLK, cpu_reg(1'b0));
      rchk(osc_ctrl_pkg::OFS_OPT, opt);
      $display("test reset done");
      t0 = ticks;
      settle(3 * osc_ctrl_pkg::SLOW_TICK_CYC);
      chk_bit(ticks - t0 == 3, 1'b1);
      $display("test watchdog tick done");
      @(posedge hclk);
      lvd_default_on <= 1'b1;
      supply_ok <= 1'b0;
      settle(2);
      chk_bit(cpu_reset_hold, 1'b1);
      @(posedge hclk);
      supply_ok <= 1'b1;
      settle(2);
      chk_bit(cpu_reset_hold, 1'b0);
      // Frozen by clock enable: supply drop must not reach the hold
      @(posedge hclk);
      clk_en <= 1'b0;
      supply_ok <= 1'b0;
      settle(3);
      chk_bit(cpu_reset_hold, 1'b0);
      @(posedge hclk);
      clk_en <= 1'b1;
      settle(2);
      chk_bit(cpu_reset_hold, 1'b1);
      @(posedge hclk);
      supply_ok <= 1'b1;
      settle(2);
      chk_bit(cpu_reset_hold, 1'b0);
      $display("test supply hold done");
      begin : mode_write
         logic [31:0] q;
         bus(1'b1, osc_ctrl_pkg::OFS_MODE, 8'hFF, 3'h2, q);
      end
      rchk(osc_ctrl_pkg::OFS_MODE, 8'h00);
      mval = (8'($urandom()) & 8'hC1) | 8'h10;
      wr(osc_ctrl_pkg::OFS_MODE, mval);
      rchk(osc_ctrl_pkg::OFS_MODE, mval & osc_ctrl_pkg::MODE_MASK);
      wr(osc_ctrl_pkg::OFS_MODE, ~mval);
      rchk(osc_ctrl_pkg::OFS_MODE, mval);
      chk_bit(sub_pins_crystal, 1'b1);
      $display("test mode register done");
      wr(osc_ctrl_pkg::OFS_RUN, 8'h00);
      settle(3);
      chk_bit(osc_en.sub_on, 1'b1);
      // Software stabilization wait
      settle(40);
      wr(osc_ctrl_pkg::OFS_CPUCLK, 8'h40);
      @(negedge hclk);
      chk_bit(cpu_clk_src === osc_ctrl_pkg::SRC_FAST, 1'b1);
      settle(8);
      chk_bit(cpu_clk_src === osc_ctrl_pkg::SRC_SUB, 1'b1);
      chk_bit(cpu_clk_div2, 1'b1);
      chk_bit(periph_on_sub, 1'b1);
      chk_bit(analog_serial_ok, 1'b0);
      rchk(osc_ctrl_pkg::OFS_CPUCLK, cpu_reg(1'b1));
      $display("test switch to subsystem done");
      // Sub status confirmed before the fast stop
      wr(osc_ctrl_pkg::OFS_RUN, 8'h01);
      settle(3);
      chk_bit(osc_en.fast_on, 1'b0);
      wr(osc_ctrl_pkg::OFS_RUN, 8'h00);
      settle(3);
      // Settle select for the main crystal sits outside this block
      pulse(3'h4);
      chk_bit(osc_en.fast_on, 1'b0);
      chk_bit(osc_en.sub_on, 1'b1);
      chk_bit(osc_en.slow_on, 1'b0);
      pulse(3'h1);
      chk_bit(osc_en.slow_on, 1'b1);
      pulse(3'h2);
      chk_bit(osc_en.slow_on, 1'b0);
      pulse(3'h1);
      chk_bit(osc_en.slow_on, 1'b1);
      $display("test standby done");
      settle(10);
      wr(osc_ctrl_pkg::OFS_CPUCLK, 8'h00);
      settle(8);
      rchk(osc_ctrl_pkg::OFS_CPUCLK, cpu_reg(1'b0));
      chk_bit(analog_serial_ok, 1'b1);
      wr(osc_ctrl_pkg::OFS_RUN, 8'h40);
      settle(3);
      chk_bit(osc_en.sub_on, 1'b0);
      wr(8'h24, 8'($urandom()));
      rchk(8'h24, 8'h00);
      $display("test subsystem stop done");
      // Main select only completes when the main crystal was enabled
      wr(osc_ctrl_pkg::OFS_CPUCLK, 8'h10);
      settle(8);
      chk_bit(cpu_clk_src === (mval[6] ? osc_ctrl_pkg::SRC_MAIN : osc_ctrl_pkg::SRC_FAST), 1'b1);
      rchk(osc_ctrl_pkg::OFS_CPUCLK, {2'h0, mval[6], 1'b1, 4'h0});
      $display("test main select done");
      do_reset(opt & 8'hEF);
      t0 = ticks;
      settle(400);
      chk_bit(osc_en.slow_on, 1'b0);
      chk_bit(ticks == t0, 1'b1);
      wr(osc_ctrl_pkg::OFS_MODE, 8'h10);
      rchk(osc_ctrl_pkg::OFS_MODE, 8'h10);
      $display("test watchdog off done");
      stop_test();
   end
endmodule : osc_stop_and_clock_select_bench
